// ===== src/dmr1_consts.vh
// Constants for the first mode register decoder
`ifndef DMR1_CONSTS_VH
`define DMR1_CONSTS_VH
`define DMR1_MR_WIDTH      17
`define DMR1_BIT_DLL_EN    0
`define DMR1_DIC_HI        2
`define DMR1_DIC_LO        1
`define DMR1_AL_HI         4
`define DMR1_AL_LO         3
`define DMR1_BIT_WLVL      7
`define DMR1_NOM_HI        10
`define DMR1_NOM_LO        8
`define DMR1_BIT_QOFF      12
`define DMR1_RSVD_MASK     17'h1E060
`define DMR1_RESET_VAL     17'h00001
`define DMR1_AL_OFF        2'h0
`define DMR1_AL_M1         2'h1
`define DMR1_AL_M2         2'h2
`define DMR1_DIC_DIV7      2'h0
`define DMR1_DIC_DIV5      2'h1
`define DMR1_SEL_MR1       3'h1
`define DMR1_CL_RESET      5'h16
`define DMR1_CWL_RESET     5'h10
`define DMR1_LOCK_CYCLES   768
`define DMR1_SYNC_RESET    11'h020
`endif

// ===== src/dmr1_term_sel.v
// Termination selector: park, nominal and write values
`timescale 1ns/1ps
`include "dmr1_consts.vh"
module dmr1_term_sel (
    // Settings
    input  wire [2:0] nom_code,
    input  wire [2:0] wr_code,
    input  wire [2:0] park_code,
    input  wire       dll_on,
    // Termination control
    input  wire       odt_in,
    input  wire       wr_active,
    output reg  [2:0] rtt_code,
    output reg        rtt_is_wr
);
    always @* begin
        rtt_is_wr = 1'b0;
        if (!odt_in) begin
            rtt_code = park_code;                         // see [RL14]
        end else if (wr_active && wr_code != 3'h0 && dll_on) begin
            rtt_code  = wr_code;                          // see [RL13] see [RL8]
            rtt_is_wr = 1'b1;
        end else if (dll_on) begin
            rtt_code = nom_code;                          // see [RL12]
        end else begin
            rtt_code = 3'h0;
        end
    end
endmodule

// ===== src/dmr1_lat_pipe.v
// Additive latency delay line for internal read/write issue
`timescale 1ns/1ps
module dmr1_lat_pipe #(
    parameter DEPTH = 32
) (
    // Clock and reset
    input  wire       clk,
    input  wire       resetn,
    // Command in and out
    input  wire       cmd_in,
    input  wire [4:0] delay,
    output wire       cmd_out
);
    reg [DEPTH-1:0] line_ff;
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            line_ff <= {DEPTH{1'b0}};
        end else begin
            line_ff <= {line_ff[DEPTH-2:0], cmd_in};
        end
    end
    // Zero delay passes through; otherwise tap the line
    assign cmd_out = (delay == 5'h0) ? cmd_in : line_ff[delay - 5'h1];
endmodule

// ===== src/dmr1_top.v
// First mode register decode and delay-locked loop control
`timescale 1ns/1ps
`include "dmr1_consts.vh"
// Rules this block is built around
// [RL1] Controller writes zeros into reserved bits
// [RL2] Bit twelve set disconnects data and strobes
// [RL3] Bit zero enables the delay-locked loop
// [RL4] Controller keeps loop on for normal use
// [RL5] Loop off in self refresh, back after
// [RL6] Controller waits lock time before reads
// [RL7] Clock enable held high during lock wait
// [RL8] Writes need loop only with write termination
// [RL9] Loop off: controller disables nominal termination
// [RL10] Loop off: controller clears write termination
// [RL11] Bits two-one select driver impedance
// [RL12] Bits ten-eight select nominal termination
// [RL13] Write termination applies without nominal termination
// [RL14] Park termination applies when control low
// [RL15] Additive latency field; codes one and two are decoded and applied, code three reads as off; all nonzero codes are flagged
// [RL16] Commands delayed by additive latency internally
// [RL17] Bit seven enables write leveling
// [RL18] Bank bits 0,0,1 select this register
module dmr1_top #(
    parameter LOCK_CYCLES = `DMR1_LOCK_CYCLES,
    parameter AL_DEPTH    = 32
) (
    // Clock and reset
    input  wire        CLK,
    input  wire        RESETN,
    // Mode-set command
    input  wire        MODE_SET,
    input  wire        BANK_GROUP_BIT0,
    input  wire        BANK_BIT1,
    input  wire        BANK_BIT0,
    input  wire [16:0] ADDR,
    input  wire        DLL_RESET,
    // Latency and other mode register settings
    input  wire [4:0]  CAS_LATENCY,
    input  wire [4:0]  CAS_WRITE_LATENCY,
    input  wire [2:0]  WRITE_TERMINATION,
    input  wire [2:0]  PARK_TERMINATION,
    // Commands and pins
    input  wire        CKE,
    input  wire        SELF_REFRESH_ENTER,
    input  wire        SELF_REFRESH_EXIT,
    input  wire        READ_CMD,
    input  wire        WRITE_CMD,
    input  wire        ON_DIE_TERMINATION,
    // Decoded state
    output reg  [16:0] MODE_REGISTER_ONE,
    output reg         DLL_ACTIVE,
    output reg         DLL_LOCKED,
    output reg         DQ_OE_N,
    output reg  [1:0]  DRIVER_IMPEDANCE_SELECT,
    output reg  [2:0]  NOMINAL_TERMINATION,
    output reg  [1:0]  ADDITIVE_LATENCY,
    output reg  [5:0]  READ_LATENCY,
    output reg  [5:0]  WRITE_LATENCY,
    output reg         WRITE_LEVELING,
    output reg  [2:0]  RTT_CODE,
    output reg         RTT_WRITE_ACTIVE,
    output reg         READ_ISSUE,
    output reg         WRITE_ISSUE,
    output reg         PROTOCOL_ERROR,
    output reg         RESERVED_ERROR
);
    localparam ST_OFF  = 4'b0001;
    localparam ST_LOCK = 4'b0010;
    localparam ST_RUN  = 4'b0100;
    localparam ST_SREF = 4'b1000;

    // Pin inputs pass a two-stage synchroniser
    reg  [10:0] s1_ff;
    reg  [10:0] s2_ff;
    reg  [16:0] a1_ff;
    reg  [16:0] a2_ff;
    always @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            // Clock enable idles high, so no false low is seen in the lock wait
            s1_ff <= `DMR1_SYNC_RESET;
            s2_ff <= `DMR1_SYNC_RESET;
            a1_ff <= 17'h00000;
            a2_ff <= 17'h00000;
        end else begin
            s1_ff <= {MODE_SET, BANK_GROUP_BIT0, BANK_BIT1, BANK_BIT0, DLL_RESET, CKE,
                      SELF_REFRESH_ENTER, SELF_REFRESH_EXIT, READ_CMD, WRITE_CMD,
                      ON_DIE_TERMINATION};
            s2_ff <= s1_ff;
            a1_ff <= ADDR;
            a2_ff <= a1_ff;
        end
    end
    wire mset  = s2_ff[10];
    wire [2:0] bsel = s2_ff[9:7];
    wire dllr  = s2_ff[6];
    wire cke   = s2_ff[5];
    wire sre   = s2_ff[4];
    wire srx   = s2_ff[3];
    wire rd    = s2_ff[2];
    wire wr    = s2_ff[1];
    wire on_die_termination   = s2_ff[0];

    function [1:0] fold_al;
        input [1:0] code;
        begin
            fold_al = (code == `DMR1_AL_M1 || code == `DMR1_AL_M2) ? code : `DMR1_AL_OFF;
        end
    endfunction

    reg  [16:0] mr_ff;
    reg  [3:0]  state_ff;
    reg  [3:0]  nxt_state;
    reg  [15:0] lock_cnt_ff;
    reg  [15:0] nxt_lock_cnt;
    wire        mr_write = mset && (bsel == `DMR1_SEL_MR1);   // see [RL18]
    wire        dll_en   = mr_ff[`DMR1_BIT_DLL_EN];           // see [RL3]
    wire [1:0]  al_code  = fold_al(mr_ff[`DMR1_AL_HI:`DMR1_AL_LO]);
    wire [4:0]  al_cyc   = (al_code == `DMR1_AL_M1) ? CAS_LATENCY - 5'h1 :
                           (al_code == `DMR1_AL_M2) ? CAS_LATENCY - 5'h2 : 5'h0;
    wire        rd_dly;
    wire        wr_dly;
    wire [2:0]  rtt_code;
    wire        write_termination;

    always @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            mr_ff <= `DMR1_RESET_VAL;
        end else if (mr_write) begin
            mr_ff <= a2_ff & ~`DMR1_RSVD_MASK;                // see [RL1]
        end
    end

    // Loop state: lock wait after enable or reset, off in self refresh
    always @* begin
        nxt_state    = state_ff;
        nxt_lock_cnt = lock_cnt_ff;
        case (state_ff)
            ST_OFF: begin
                if (dll_en) begin
                    nxt_state    = ST_LOCK;
                    nxt_lock_cnt = 16'h0000;
                end
            end
            ST_LOCK: begin
                nxt_lock_cnt = lock_cnt_ff + 16'h0001;
                if (!dll_en) begin
                    nxt_state = ST_OFF;
                end else if (sre) begin
                    nxt_state = ST_SREF;                      // see [RL5]
                end else if (lock_cnt_ff >= LOCK_CYCLES[15:0] - 16'h0001) begin
                    nxt_state = ST_RUN;
                end
            end
            ST_RUN: begin
                if (!dll_en) begin
                    nxt_state = ST_OFF;
                end else if (sre) begin
                    nxt_state = ST_SREF;                      // see [RL5]
                end else if (dllr) begin
                    nxt_state    = ST_LOCK;
                    nxt_lock_cnt = 16'h0000;
                end
            end
            ST_SREF: begin
                if (srx) begin
                    nxt_state    = dll_en ? ST_LOCK : ST_OFF; // see [RL5]
                    nxt_lock_cnt = 16'h0000;
                end
            end
            default: begin
                nxt_state = ST_OFF;
            end
        endcase
    end

    always @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            state_ff    <= ST_OFF;
            lock_cnt_ff <= 16'h0000;
        end else begin
            state_ff    <= nxt_state;
            lock_cnt_ff <= nxt_lock_cnt;
        end
    end

    dmr1_lat_pipe #(
        .DEPTH   (AL_DEPTH)
    ) u_rd_pipe (
        .clk     (CLK),
        .resetn  (RESETN),
        .cmd_in  (rd),
        .delay   (al_cyc),
        .cmd_out (rd_dly)
    );

    dmr1_lat_pipe #(
        .DEPTH   (AL_DEPTH)
    ) u_wr_pipe (
        .clk     (CLK),
        .resetn  (RESETN),
        .cmd_in  (wr),
        .delay   (al_cyc),
        .cmd_out (wr_dly)
    );

    dmr1_term_sel u_term (
        .nom_code  (mr_ff[`DMR1_NOM_HI:`DMR1_NOM_LO]),
        .wr_code   (WRITE_TERMINATION),
        .park_code (PARK_TERMINATION),
        .dll_on    (state_ff == ST_RUN),
        .odt_in    (on_die_termination),
        .wr_active (wr_dly),
        .rtt_code  (rtt_code),
        .rtt_is_wr (write_termination)
    );

    // Registered outputs
    always @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            MODE_REGISTER_ONE       <= `DMR1_RESET_VAL;
            DLL_ACTIVE              <= 1'b0;
            DLL_LOCKED              <= 1'b0;
            DQ_OE_N                 <= 1'b1;
            DRIVER_IMPEDANCE_SELECT <= `DMR1_DIC_DIV7;
            NOMINAL_TERMINATION     <= 3'h0;
            ADDITIVE_LATENCY        <= `DMR1_AL_OFF;
            READ_LATENCY            <= {1'b0, `DMR1_CL_RESET};
            WRITE_LATENCY           <= {1'b0, `DMR1_CWL_RESET};
            WRITE_LEVELING          <= 1'b0;
            RTT_CODE                <= 3'h0;
            RTT_WRITE_ACTIVE        <= 1'b0;
            READ_ISSUE              <= 1'b0;
            WRITE_ISSUE             <= 1'b0;
            PROTOCOL_ERROR          <= 1'b0;
            RESERVED_ERROR          <= 1'b0;
        end else begin
            MODE_REGISTER_ONE       <= mr_ff;
            DLL_ACTIVE              <= (state_ff == ST_LOCK) || (state_ff == ST_RUN);
            DLL_LOCKED              <= (state_ff == ST_RUN);
            // Low means driving; bit twelve forces the outputs off
            DQ_OE_N                 <= mr_ff[`DMR1_BIT_QOFF];          // see [RL2]
            DRIVER_IMPEDANCE_SELECT <= mr_ff[`DMR1_DIC_HI:`DMR1_DIC_LO]; // see [RL11]
            NOMINAL_TERMINATION     <= mr_ff[`DMR1_NOM_HI:`DMR1_NOM_LO]; // see [RL12]
            ADDITIVE_LATENCY        <= al_code;                        // see [RL15]
            READ_LATENCY            <= {1'b0, al_cyc} + {1'b0, CAS_LATENCY};       // see [RL16]
            WRITE_LATENCY           <= {1'b0, al_cyc} + {1'b0, CAS_WRITE_LATENCY}; // see [RL16]
            WRITE_LEVELING          <= mr_ff[`DMR1_BIT_WLVL];          // see [RL17]
            RTT_CODE                <= rtt_code;                       // see [RL14]
            RTT_WRITE_ACTIVE        <= write_termination;                         // see [RL13]
            READ_ISSUE              <= rd_dly;                         // see [RL16]
            WRITE_ISSUE             <= wr_dly;                         // see [RL8]
            // Sticky flag: read during lock, clock enable low in lock, loop-off termination
            PROTOCOL_ERROR          <= PROTOCOL_ERROR
                                     | (rd && state_ff == ST_LOCK)     // see [RL6]
                                     | (!cke && state_ff == ST_LOCK)   // see [RL7]
                                     | (state_ff == ST_OFF && on_die_termination &&
                                        mr_ff[`DMR1_NOM_HI:`DMR1_NOM_LO] != 3'h0) // see [RL9]
                                     | (state_ff == ST_OFF && WRITE_TERMINATION != 3'h0); // see [RL10]
            RESERVED_ERROR          <= RESERVED_ERROR
                                     | (mr_write && (a2_ff & `DMR1_RSVD_MASK) != 17'h00000)
                                     | (mr_write && a2_ff[`DMR1_AL_HI:`DMR1_AL_LO] != 2'h0);
        end
    end
endmodule

// ===== verif/dmr1_top_properties.sv
// Port-level checks for the first mode register decoder
`timescale 1ns/1ps
module dmr1_chk #(
    parameter LOCK_CYCLES = 768
) (
    // Clock and reset
    input wire        CLK,
    input wire        RESETN,
    // Watched inputs
    input wire        READ_CMD,
    input wire        WRITE_CMD,
    input wire        ON_DIE_TERMINATION,
    input wire [4:0]  CAS_LATENCY,
    input wire [2:0]  PARK_TERMINATION,
    // Watched outputs
    input wire [16:0] MODE_REGISTER_ONE,
    input wire        DLL_ACTIVE,
    input wire        DLL_LOCKED,
    input wire        DQ_OE_N,
    input wire [1:0]  DRIVER_IMPEDANCE_SELECT,
    input wire [2:0]  NOMINAL_TERMINATION,
    input wire [1:0]  ADDITIVE_LATENCY,
    input wire [5:0]  READ_LATENCY,
    input wire        WRITE_LEVELING,
    input wire [2:0]  RTT_CODE,
    input wire        READ_ISSUE,
    input wire        WRITE_ISSUE,
    input wire        RESERVED_ERROR
);
    localparam int LKMAX = LOCK_CYCLES + 8;
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESETN);
    // Register settled long enough for the decode to follow
    sequence s_st;
        $stable(MODE_REGISTER_ONE)[*4];
    endsequence
    AST_QOFF: assert property (
        s_st |-> DQ_OE_N == MODE_REGISTER_ONE[12]) else $error("qoff");
    AST_RSVD: assert property (
        (MODE_REGISTER_ONE & 17'h1E060) == 17'h00000) else $error("rsvd");
    AST_DIC: assert property (
        s_st |-> DRIVER_IMPEDANCE_SELECT == MODE_REGISTER_ONE[2:1]) else $error("dic");
    AST_NOM: assert property (
        s_st |-> NOMINAL_TERMINATION == MODE_REGISTER_ONE[10:8]) else $error("nom");
    AST_WLVL: assert property (
        s_st |-> WRITE_LEVELING == MODE_REGISTER_ONE[7]) else $error("wlvl");
    AST_RLAT: assert property (
        s_st ##0 ADDITIVE_LATENCY == 2'h0 |-> READ_LATENCY == {1'b0, CAS_LATENCY})
        else $error("rlat");
    AST_ISSUE: assert property (
        (ADDITIVE_LATENCY == 2'h0 && DLL_LOCKED)[*6] |-> READ_ISSUE == $past(READ_CMD, 3))
        else $error("issue");
    AST_WISSUE: assert property (
        (ADDITIVE_LATENCY == 2'h0 && DLL_LOCKED)[*6] |-> WRITE_ISSUE == $past(WRITE_CMD, 3))
        else $error("wissue");
    AST_LKACT: assert property (
        $rose(DLL_LOCKED) |-> $past(DLL_ACTIVE, LOCK_CYCLES)) else $error("lkact");
    AST_LKMAX: assert property (
        $rose(DLL_ACTIVE) |-> ##[1:LKMAX] DLL_LOCKED) else $error("lkmax");
    AST_PARK: assert property (
        (!ON_DIE_TERMINATION && $stable(PARK_TERMINATION))[*5] |-> RTT_CODE == PARK_TERMINATION)
        else $error("park");
    cover property ($rose(DLL_LOCKED));
    cover property ($rose(RESERVED_ERROR));
    cover property (DQ_OE_N && DLL_LOCKED);
endmodule

bind dmr1_top dmr1_chk #(.LOCK_CYCLES(LOCK_CYCLES)) u_chk (
    .CLK, .RESETN, .READ_CMD, .ON_DIE_TERMINATION, .CAS_LATENCY, .PARK_TERMINATION,
    .MODE_REGISTER_ONE, .DLL_ACTIVE, .DLL_LOCKED, .DQ_OE_N, .DRIVER_IMPEDANCE_SELECT,
    .NOMINAL_TERMINATION, .ADDITIVE_LATENCY, .READ_LATENCY, .WRITE_LEVELING, .RTT_CODE,
    .READ_ISSUE, .RESERVED_ERROR, .WRITE_CMD, .WRITE_ISSUE);

// ===== verif/dmr1_ctrl_model.sv
// Memory controller model issuing mode-set and access commands
`timescale 1ns/1ps
`include "dmr1_consts.vh"
module dmr1_ctrl_model (
    // Clock
    input  wire        clk,
    // Mode-set command
    output reg         ms,
    output reg  [2:0]  sel,
    output reg  [16:0] adr,
    // Clock enable and pulses: read, write, sref in, sref out, loop reset
    output reg         cke,
    output reg  [4:0]  pls
);
    initial begin
        ms = 1'b0;
        sel = 3'h0;
        adr = 17'h00000;
        cke = 1'b1;
        pls = 5'h00;
    end
    // Raw skips the cleanup; only the bad-write scenario sets it
    task automatic mode_set_command(input [2:0] s, input [16:0] v, input raw);
        reg [16:0] w;
        begin
            w = raw ? v : v & ~`DMR1_RSVD_MASK;
            if (!raw && !w[0]) w[10:8] = 3'h0;
            @(posedge clk);
            ms <= 1'b1;
            sel <= s;
            adr <= w;
            @(posedge clk);
            ms <= 1'b0;
            sel <= ~s;
            adr <= ~w;
        end
    endtask
    task automatic hold(input int k, input int n);
        begin
            @(posedge clk);
            pls[k] <= 1'b1;
            repeat (n) @(posedge clk);
            pls[k] <= 1'b0;
        end
    endtask
endmodule

// ===== verif/dram_mode_register_one_decode_tb.sv
// Self-checking bench for the first mode register decoder
`timescale 1ns/1ps
`include "dmr1_consts.vh"
module dram_mode_register_one_decode_tb;
    reg         clk = 1'b0;
    reg         rst_n = 1'b0;
    reg  [2:0]  wt = 3'h0;
    reg  [2:0]  park = 3'h0;
    reg         on_die_termination = 1'b0;
    wire        ms, cke, oe_n, act, lk, wlv, rwa, rerr, perr;
    wire [2:0]  sel, nom, rtt;
    wire [16:0] adr, mr1;
    wire [4:0]  pls;
    wire [1:0]  driver_impedance_select, al;
    wire [5:0]  rl, wl;
    reg  [16:0] e_mr = 17'h00001;
    reg  [1:0]  e_al = 2'h0;
    reg  [5:0]  e_rl = 6'h16, e_wl = 6'h10;
    reg         e_rst = 1'b1, e_act = 1'b0, e_lk = 1'b0, e_rwa = 1'b0, e_re = 1'b0, e_pe = 1'b0;
    reg  [16:0] v;
    int         cyc = 0, n_fail = 0, total_checks = 0, i;
    int         dq[$];
    reg  [45:0] eq[$];

    dmr1_ctrl_model mc (.clk(clk), .ms(ms), .sel(sel), .adr(adr), .cke(cke), .pls(pls));
    dmr1_top #(.LOCK_CYCLES(16)) dut (
        .CLK(clk), .RESETN(rst_n), .MODE_SET(ms), .BANK_GROUP_BIT0(sel[2]), .BANK_BIT1(sel[1]),
        .BANK_BIT0(sel[0]), .ADDR(adr), .DLL_RESET(pls[4]), .CAS_LATENCY(5'h16),
        .CAS_WRITE_LATENCY(5'h10), .WRITE_TERMINATION(wt), .PARK_TERMINATION(park), .CKE(cke),
        .SELF_REFRESH_ENTER(pls[2]), .SELF_REFRESH_EXIT(pls[3]), .READ_CMD(pls[0]),
        .WRITE_CMD(pls[1]), .ON_DIE_TERMINATION(on_die_termination), .MODE_REGISTER_ONE(mr1), .DLL_ACTIVE(act),
        .DLL_LOCKED(lk), .DQ_OE_N(oe_n), .DRIVER_IMPEDANCE_SELECT(driver_impedance_select), .NOMINAL_TERMINATION(nom),
        .ADDITIVE_LATENCY(al), .READ_LATENCY(rl), .WRITE_LATENCY(wl), .WRITE_LEVELING(wlv),
        .RTT_CODE(rtt), .RTT_WRITE_ACTIVE(rwa), .READ_ISSUE(), .WRITE_ISSUE(),
        .PROTOCOL_ERROR(perr), .RESERVED_ERROR(rerr));

    always #10 clk = ~clk;

    task give_verdict;
        begin
            $display("checks %0d failures %0d", total_checks, n_fail);
            if (n_fail == 0 && total_checks > 0)
                $display("TB: PASS");
            else
                $display("TB: FAIL");
            $finish;
        end
    endtask
    task automatic chk(input [45:0] o, input [45:0] e);
        begin
            total_checks++;
            if (o !== e) begin
                n_fail++;
                $display("ERROR %0t: saw %h expected %h", $time, o, e);
            end
        end
    endtask
    // Note the expected port state, due d cycles from now
    task automatic push(input int d);
        begin
            dq.push_back(cyc + d);
            eq.push_back({e_mr, e_mr[12] | e_rst, e_mr[2:1], e_mr[10:8], e_al, e_rl, e_wl,
                e_mr[7], e_act, e_lk, e_rst ? 3'h0 : (e_rwa ? wt : park), e_rwa, e_re, e_pe});
        end
    endtask
    task automatic wlk();
        int k;
        begin
            for (k = 0; k < 100 && lk !== 1'b1; k++) @(posedge clk);
            e_act = 1'b1;
            e_lk = 1'b1;
            push(2);
        end
    endtask

    // Outputs are looked at on the falling edge, where they have settled
    always @(negedge clk) begin
        cyc++;
        if (cyc > 2000) begin
            n_fail++;
            give_verdict;
        end else begin
            while (dq.size() > 0 && dq[0] <= cyc) begin
                chk({mr1, oe_n, driver_impedance_select, nom, al, rl, wl, wlv, act, lk, rtt, rwa, rerr, perr}, eq[0]);
                void'(dq.pop_front());
                void'(eq.pop_front());
            end
        end
    end

    initial begin
        void'($urandom(32'h0C37895E));
        park <= 3'($urandom);
        repeat (20) @(posedge clk);
        push(0);
        rst_n <= 1'b1;
        e_rst = 1'b0;
        wlk();
        for (i = 0; i < 8; i++) begin
            v = 17'($urandom);
            v[0] = 1'b1;
            v[4:3] = 2'h0;
            mc.mode_set_command(3'h1, v, 1'b0);
            e_mr = v & ~`DMR1_RSVD_MASK;
            push(8);
            repeat (8) @(posedge clk);
            mc.hold(0, 1);
        end
        mc.mode_set_command(3'h2, 17'h1FFFF, 1'b0);
        push(8);
        repeat (8) @(posedge clk);
        mc.mode_set_command(3'h1, e_mr | `DMR1_RSVD_MASK, 1'b1);
        e_re = 1'b1;
        push(8);
        repeat (8) @(posedge clk);
        for (i = 1; i < 4; i++) begin
            mc.mode_set_command(3'h1, {12'h000, i[1:0], 3'h1}, 1'b0);
            e_mr = {12'h000, i[1:0], 3'h1};
            e_al = (i == 3) ? 2'h0 : i[1:0];
            e_rl = (i == 3) ? 6'h16 : 6'h2C - {4'h0, e_al};
            e_wl = (i == 3) ? 6'h10 : 6'h26 - {4'h0, e_al};
            push(8);
            repeat (8) @(posedge clk);
        end
        wt <= 3'h1 + 3'($urandom % 7);
        on_die_termination <= 1'b1;
        fork
            mc.hold(1, 12);
        join_none
        repeat (4) @(posedge clk);
        e_rwa = 1'b1;
        push(5);
        repeat (12) @(posedge clk);
        on_die_termination <= 1'b0;
        e_rwa = 1'b0;
        push(8);
        repeat (8) @(posedge clk);
        mc.hold(2, 1);
        e_act = 1'b0;
        e_lk = 1'b0;
        push(8);
        repeat (8) @(posedge clk);
        mc.hold(3, 1);
        wlk();
        mc.hold(4, 1);
        e_lk = 1'b0;
        push(6);
        repeat (8) @(posedge clk);
        wlk();
        wt <= 3'h0;
        mc.mode_set_command(3'h1, 17'h00700, 1'b0);
        e_mr = 17'h00000;
        e_act = 1'b0;
        e_lk = 1'b0;
        push(8);
        repeat (8) @(posedge clk);
        mc.mode_set_command(3'h1, 17'h00001, 1'b0);
        e_mr = 17'h00001;
        wlk();
        // Let the pending lock check land before reset hits again
        repeat (4) @(posedge clk);
        rst_n <= 1'b0;
        e_rst = 1'b1;
        e_act = 1'b0;
        e_lk = 1'b0;
        e_re = 1'b0;
        repeat (3) @(posedge clk);
        push(0);
        rst_n <= 1'b1;
        e_rst = 1'b0;
        repeat (4) @(posedge clk);
        // Read inside the lock wait, deliberately early
        mc.hold(0, 1);
        e_pe = 1'b1;
        wlk();
        repeat (4) @(posedge clk);
        give_verdict;
    end
endmodule
